// *** design/mba_arbiter.sv ***
// Summary of operation
// - Grant drives address enable low immediately.
// - Address enable rises only after hold time.
// - Keep release and inhibit synchronised, any time.
// - Front generator runs while status active.
// - Back generator runs while status passive.
// - Resident mode requests late, system accesses only.
// - I/O mode requests only for memory cycles.
// - Single mode requests on active status edge.
// - Request synchronised to bus clock first.
// - With priority, seize busy one clock after high.
// - Surrender on lost priority or idle request.
// - Surrender drops address enable, clears request.
// - Cleared request removes bus request output.
// - Surrender only inside the release window.
// - Straps select I/O, resident or single.
// - Both straps apply both qualifications.
// - Bus keep blocks any surrender.
// - Inhibit blocks surrender to lower priority.
// - Any strap releases to any requester.
`timescale 1ns/10ps
`default_nettype none
module mba_arbiter
   import mba_pkg::*;
#(
   parameter int HOLD_CYC = CMD_HOLD_CYC,
   parameter int DECODE_CYC = STATUS_DECODE_CYC,
   parameter int RESIDENT_CYC = RESIDENT_SETTLE_CYC,
   parameter int IDLE_CYC = IDLE_DETECT_CYC
) (
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire logic bus_clk_i,
   input wire logic [STATUS_W-1:0] status_n_i,
   input wire logic system_or_resident_select_i,
   input wire logic io_bus_strap_i,
   input wire logic resident_bus_strap_i,
   input wire logic surrender_to_any_strap_i,
   input wire logic bus_keep_n_i,
   input wire logic common_request_inhibit_i,
   input wire logic priority_in_n_i,
   input wire logic busy_i,
   input wire logic common_bus_request_n_i,
   output logic address_enable_n_o,
   output logic bus_request_out_n_o,
   output logic busy_o,
   output logic busy_oe_o
);
   localparam logic [CNT_W-1:0] HOLD_CNT = CNT_W'(HOLD_CYC);
   localparam logic [CNT_W-1:0] DECODE_CNT = CNT_W'(DECODE_CYC);
   localparam logic [CNT_W-1:0] RESIDENT_CNT = CNT_W'(RESIDENT_CYC);
   localparam logic [CNT_W-1:0] IDLE_CNT = CNT_W'(IDLE_CYC);

   if (HOLD_CYC < 1 || HOLD_CYC >= IDLE_CYC) begin : g_bad_hold
      $error("mba_arbiter: bad HOLD_CYC");
   end
   if (DECODE_CYC < 1 || RESIDENT_CYC < 1) begin : g_bad_delay
      $error("mba_arbiter: bad request delay");
   end
   if (IDLE_CYC > 126) begin : g_bad_idle
      $error("mba_arbiter: IDLE_CYC exceeds counter");
   end

   // Processor clock domain
   logic [PS_W-1:0] psync_in;
   logic [PS_W-1:0] psync;
   logic [CNT_W-1:0] front_cnt;
   logic [CNT_W-1:0] back_cnt;
   logic bus_own_r;

   assign psync_in = {bus_own_r, common_bus_request_n_i, priority_in_n_i,
                      system_or_resident_select_i, common_request_inhibit_i, bus_keep_n_i,
                      resident_bus_strap_i, io_bus_strap_i, surrender_to_any_strap_i,
                      status_n_i};

   mba_sync2 #(
      .WIDTH(PS_W)
   ) u_psync (
      .clk_i(ref_clk_i),
      .d_i(psync_in),
      .q_o(psync)
   );

   wire [STATUS_W-1:0] status_s = psync[PS_STATUS_LSB +: STATUS_W];
   wire any_s = psync[PS_ANY_STRAP];
   wire io_s = psync[PS_IO_STRAP];
   wire res_s = psync[PS_RES_STRAP];
   wire keep_s = !psync[PS_KEEP_N];
   wire inhibit_s = psync[PS_INHIBIT];
   wire sys_sel_s = psync[PS_SYS_SEL];
   wire lost_s = psync[PS_PRIO_N];
   wire common_bus_request_low_s = !psync[PS_COMMON_BUS_REQUEST_N];
   wire own_p = psync[PS_BUS_OWN];

   wire stat_active = (status_s != STATUS_PASSIVE);
   wire mem_cycle = status_s[STATUS_MEM_BIT] && stat_active;

   mba_cycle_track #(
      .CW(CNT_W)
   ) u_track (
      .clk_i(ref_clk_i),
      .rstn_i(rstn_i),
      .active_i(stat_active),
      .front_cnt_o(front_cnt),
      .back_cnt_o(back_cnt)
   );

   // Request point in the cycle and its qualification per mode
   wire [CNT_W-1:0] req_delay = res_s ? RESIDENT_CNT : (io_s ? DECODE_CNT : CNT_ZERO);
   wire cycle_qual = (!io_s || mem_cycle) && (!res_s || sys_sel_s);
   wire req_point = stat_active && (front_cnt == req_delay);
   wire request_w = req_point && cycle_qual;

   logic req_set_r;
   logic last_qual_r;
   logic req_set_nxt;
   logic last_qual_nxt;
   logic aen_n_nxt;

   // Idle: passive beyond command termination, or last cycle not ours
   wire processor_idle_state = !stat_active && (back_cnt >= IDLE_CNT);
   wire idle_like = processor_idle_state || !last_qual_r;
   wire release_window = !stat_active && (back_cnt >= HOLD_CNT);
   wire low_prio_take = common_bus_request_low_s && !inhibit_s && (idle_like || any_s);
   wire surr_cond = !keep_s && (lost_s || low_prio_take);
   wire surrender_w = req_set_r && own_p && release_window && surr_cond;

   assign last_qual_nxt = req_point ? cycle_qual : last_qual_r;
   // Request and surrender fall in opposite status phases
   assign req_set_nxt = request_w ? 1'h1 : (surrender_w ? 1'h0 : req_set_r);
   assign aen_n_nxt = !(req_set_nxt && own_p);

   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         req_set_r <= 1'h0;
         last_qual_r <= 1'h0;
         address_enable_n_o <= 1'h1;
      end else begin
         req_set_r <= req_set_nxt;
         last_qual_r <= last_qual_nxt;
         address_enable_n_o <= aen_n_nxt;
      end
   end

   // Bus clock domain
   logic brst_meta_r;
   logic brst_n_r;

   // Reset brought into the bus domain through two stages
   always_ff @(posedge bus_clk_i) begin
      brst_meta_r <= rstn_i;
      brst_n_r <= brst_meta_r;
   end

   logic [BS_W-1:0] bsync;

   mba_sync2 #(
      .WIDTH(BS_W)
   ) u_bsync (
      .clk_i(bus_clk_i),
      .d_i({address_enable_n_o, req_set_r}),
      .q_o(bsync)
   );

   wire req_b = bsync[BS_REQ_SET];
   wire aen_n_b = bsync[BS_AEN_N];

   mba_bus_state_e bstate_r;
   mba_bus_state_e bstate_nxt;

   always_comb begin
      bstate_nxt = bstate_r;
      case (bstate_r)
         MBA_B_IDLE: begin
            if (req_b) bstate_nxt = MBA_B_WAIT;
         end
         MBA_B_WAIT: begin
            if (!req_b) bstate_nxt = MBA_B_IDLE;
            else if (!priority_in_n_i && busy_i) bstate_nxt = MBA_B_OWN;
         end
         MBA_B_OWN: begin
            // Local commands may still be enabled until address enable is seen high
            if (!req_b && aen_n_b) bstate_nxt = MBA_B_IDLE;
         end
         default: bstate_nxt = MBA_B_IDLE;
      endcase
   end

   wire own_nxt = (bstate_nxt == MBA_B_OWN);

   always_ff @(posedge bus_clk_i) begin
      if (!brst_n_r) begin
         bstate_r <= MBA_B_IDLE;
         bus_own_r <= 1'h0;
         busy_oe_o <= 1'h0;
         busy_o <= 1'h0;
         bus_request_out_n_o <= 1'h1;
      end else begin
         bstate_r <= bstate_nxt;
         bus_own_r <= own_nxt;
         busy_oe_o <= own_nxt;
         busy_o <= 1'h0;
         bus_request_out_n_o <= !req_b;
      end
   end

   // Checks, processor domain
   chk_aen_grant: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      (req_set_r && own_p && !surrender_w) |=> !address_enable_n_o)
      else $error("address enable not asserted on grant");

   chk_hold_window: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      $fell(req_set_r) |-> $past(back_cnt) >= HOLD_CNT && !$past(stat_active))
      else $error("surrender before command hold time");

   chk_front_start: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      (stat_active && front_cnt == CNT_ZERO) |=> front_cnt == CNT_ONE || !stat_active)
      else $error("front generator did not start");

   chk_back_reset: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      stat_active |=> back_cnt == CNT_ZERO)
      else $error("back generator not reset by active status");

   chk_single_req: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      (!io_s && !res_s && stat_active && front_cnt == CNT_ZERO) |=> req_set_r)
      else $error("single mode request missing");

   chk_io_filter: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      (io_s && $rose(req_set_r)) |-> $past(mem_cycle))
      else $error("request raised for non-memory cycle");

   chk_resident_late: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      (res_s && $rose(req_set_r)) |-> $past(front_cnt) == RESIDENT_CNT && $past(sys_sel_s))
      else $error("resident mode request at wrong point");

   chk_keep_hold: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      (req_set_r && keep_s) |=> req_set_r)
      else $error("bus surrendered while kept");

   chk_inhibit_hold: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      (req_set_r && inhibit_s && !lost_s) |=> req_set_r)
      else $error("bus surrendered to lower priority under inhibit");

   chk_surr_clear: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      surrender_w |=> !req_set_r && address_enable_n_o)
      else $error("surrender did not clear request and enable");

   chk_keep_bus: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      (req_set_r && !lost_s && !common_bus_request_low_s) |=> req_set_r)
      else $error("bus dropped without cause");

   chk_lost_release: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      (req_set_r && own_p && release_window && lost_s && !keep_s)
      |=> !req_set_r && address_enable_n_o)
      else $error("bus not surrendered after lost priority");

   chk_idle_release: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      (req_set_r && own_p && processor_idle_state && common_bus_request_low_s && !inhibit_s && !keep_s)
      |=> !req_set_r)
      else $error("bus not surrendered to idle request");

   chk_any_release: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      (req_set_r && own_p && release_window && any_s && common_bus_request_low_s && !inhibit_s && !keep_s)
      |=> !req_set_r)
      else $error("bus not released to any requester");

   chk_aen_own: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      !own_p |=> address_enable_n_o)
      else $error("address enable asserted without the bus");

   // Checks, bus domain
   chk_seize_delay: assert property (@(posedge bus_clk_i) disable iff (!brst_n_r)
      (bstate_r == MBA_B_WAIT && req_b && !priority_in_n_i && busy_i) |=> busy_oe_o)
      else $error("busy not seized one clock after free");

   chk_bus_request_out_follow: assert property (@(posedge bus_clk_i) disable iff (!brst_n_r)
      req_b |=> !bus_request_out_n_o ##0 $past(req_b) == !bus_request_out_n_o)
      else $error("bus request does not follow synchronised request");

   chk_busy_release: assert property (@(posedge bus_clk_i) disable iff (!brst_n_r)
      $fell(busy_oe_o) |-> $past(aen_n_b) && !$past(req_b))
      else $error("busy released while address enable active");

   chk_no_seize: assert property (@(posedge bus_clk_i) disable iff (!brst_n_r)
      (bstate_r == MBA_B_WAIT && (priority_in_n_i || !busy_i)) |=> !busy_oe_o)
      else $error("busy seized without priority or while taken");

   chk_busy_kept: assert property (@(posedge bus_clk_i) disable iff (!brst_n_r)
      (bstate_r == MBA_B_OWN && (req_b || !aen_n_b)) |=> busy_oe_o)
      else $error("busy released early");

   cov_seize: cover property (@(posedge bus_clk_i) disable iff (!brst_n_r)
      $rose(busy_oe_o));

   cov_surrender: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
      surrender_w && lost_s);

   cov_low_prio: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
      surrender_w && !lost_s && processor_idle_state);

   cov_resident_req: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
      res_s && io_s && $rose(req_set_r));

   cov_keep_block: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
      req_set_r && keep_s && lost_s && release_window);
endmodule
`default_nettype wire

// *** design/mba_cycle_track.sv ***
`timescale 1ns/10ps
`default_nettype none
module mba_cycle_track
   import mba_pkg::*;
#(
   parameter int CW = CNT_W
) (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic active_i,
   output logic [CW-1:0] front_cnt_o,
   output logic [CW-1:0] back_cnt_o
);
   logic [CW-1:0] front_nxt;
   logic [CW-1:0] back_nxt;

   if (CW < 2) begin : g_bad_width
      $error("mba_cycle_track: CW too small");
   end

   // Counters saturate so long waits or idles never wrap
   assign front_nxt = !active_i ? '0 : (&front_cnt_o ? front_cnt_o : front_cnt_o + 1'h1);
   assign back_nxt = active_i ? '0 : (&back_cnt_o ? back_cnt_o : back_cnt_o + 1'h1);

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         front_cnt_o <= '0;
         back_cnt_o <= '0;
      end else begin
         front_cnt_o <= front_nxt;
         back_cnt_o <= back_nxt;
      end
   end
endmodule
`default_nettype wire

// *** design/mba_pkg.sv ***
package mba_pkg;

   // Processor status lines, active low; all high means passive
   localparam int STATUS_W = 3;
   localparam logic [STATUS_W-1:0] STATUS_PASSIVE = 3'h7;
   localparam int STATUS_MEM_BIT = 2;

   // Positions inside the processor-side synchroniser vector
   localparam int PS_STATUS_LSB = 0;
   localparam int PS_ANY_STRAP = 3;
   localparam int PS_IO_STRAP = 4;
   localparam int PS_RES_STRAP = 5;
   localparam int PS_KEEP_N = 6;
   localparam int PS_INHIBIT = 7;
   localparam int PS_SYS_SEL = 8;
   localparam int PS_PRIO_N = 9;
   localparam int PS_COMMON_BUS_REQUEST_N = 10;
   localparam int PS_BUS_OWN = 11;
   localparam int PS_W = 12;

   // Positions inside the bus-side synchroniser vector
   localparam int BS_REQ_SET = 0;
   localparam int BS_AEN_N = 1;
   localparam int BS_W = 2;

   // Timing, processor clock at 200 MHz
   localparam int REF_CLK_MHZ = 200;
   localparam int CMD_HOLD_NS = 20;
   localparam int STATUS_DECODE_NS = 10;
   localparam int RESIDENT_SETTLE_NS = 20;
   localparam int IDLE_DETECT_NS = 400;
   // Least times round up to whole cycles
   localparam int CMD_HOLD_CYC = (CMD_HOLD_NS * REF_CLK_MHZ + 999) / 1000;
   localparam int STATUS_DECODE_CYC = (STATUS_DECODE_NS * REF_CLK_MHZ + 999) / 1000;
   localparam int RESIDENT_SETTLE_CYC = (RESIDENT_SETTLE_NS * REF_CLK_MHZ + 999) / 1000;
   localparam int IDLE_DETECT_CYC = (IDLE_DETECT_NS * REF_CLK_MHZ + 999) / 1000;

   localparam int CNT_W = 7;
   localparam logic [CNT_W-1:0] CNT_ZERO = 7'h00;
   localparam logic [CNT_W-1:0] CNT_ONE = 7'h01;
   localparam logic [CNT_W-1:0] CNT_MAX = 7'h7F;

   typedef enum logic [2:0] {
      MBA_B_IDLE = 3'h1,
      MBA_B_WAIT = 3'h2,
      MBA_B_OWN = 3'h4
   } mba_bus_state_e;

endpackage

// *** design/mba_sync2.sv ***
`timescale 1ns/10ps
`default_nettype none
module mba_sync2 #(
   parameter int WIDTH = 1
) (
   input wire logic clk_i,
   input wire logic [WIDTH-1:0] d_i,
   output logic [WIDTH-1:0] q_o
);
   logic [WIDTH-1:0] meta_r;

   if (WIDTH < 1) begin : g_bad_width
      $error("mba_sync2: WIDTH must be at least 1");
   end

   // First stage feeds only the second stage
   always_ff @(posedge clk_i) begin
      meta_r <= d_i;
      q_o <= meta_r;
   end
endmodule
`default_nettype wire

// *** testbench/mba_far_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module mba_far_model (
   input wire logic ref_clk_i,
   input wire logic aen_n_i,
   input wire logic bus_clk_i,
   input wire logic bus_request_out_n_i,
   input wire logic busy_oe_i,
   input wire logic busy_val_i,
   input wire logic rival_i,
   input wire logic hog_i,
   input wire logic low_req_i,
   output logic prio_n_o,
   output logic busy_o,
   output logic common_bus_request_n_o,
   output logic cmd_o
);
   logic [1:0] setup_r;

   // Controller: commands stay disqualified until setup has elapsed
   always_ff @(posedge ref_clk_i) begin
      if (aen_n_i) begin
         setup_r <= 2'h0;
      end else if (setup_r != 2'h3) begin
         setup_r <= setup_r + 2'h1;
      end
      cmd_o <= !aen_n_i && (setup_r == 2'h3);
   end
   // Resolver settles one bus clock after the requests change
   always_ff @(posedge bus_clk_i) begin
      prio_n_o <= bus_request_out_n_i | rival_i;
      common_bus_request_n_o <= ~low_req_i;
   end
   // Pulled-up wire; another master may hold it low
   assign busy_o = (busy_oe_i ? busy_val_i : 1'h1) & ~hog_i;
endmodule
`default_nettype wire

// *** testbench/tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb;
   import mba_pkg::*;
   localparam int IDLE = 10;
   typedef struct packed {
      logic io;
      logic res;
      logic sel;
      logic [2:0] st;
      logic req;
   } mba_row_s;
   mba_row_s rows [9] = '{
      '{1'h0, 1'h0, 1'h0, 3'h5, 1'h1},
      '{1'h0, 1'h0, 1'h0, 3'h1, 1'h1},
      '{1'h1, 1'h0, 1'h1, 3'h5, 1'h1},
      '{1'h1, 1'h0, 1'h1, 3'h1, 1'h0},
      '{1'h0, 1'h1, 1'h1, 3'h1, 1'h1},
      '{1'h0, 1'h1, 1'h0, 3'h5, 1'h0},
      '{1'h1, 1'h1, 1'h1, 3'h5, 1'h1},
      '{1'h1, 1'h1, 1'h0, 3'h5, 1'h0},
      '{1'h1, 1'h1, 1'h1, 3'h1, 1'h0}
   };
   logic ref_clk_i = 1'h0;
   logic bus_clk_i = 1'h0;
   logic rstn_i = 1'h0;
   logic [STATUS_W-1:0] status_n = STATUS_PASSIVE;
   logic sel = 1'h0;
   logic io_s = 1'h0;
   logic res_s = 1'h0;
   logic any_s = 1'h0;
   logic keep_n = 1'h1;
   logic inh = 1'h0;
   logic rival = 1'h0;
   logic hog = 1'h0;
   logic low_req = 1'h0;
   logic aen_n, bus_request_out_n, busy_val, busy_oe, prio_n, busy_w, common_bus_request_n, cmd;
   int bad_count = 0;
   int checks_done = 0;
   int n;

   mba_arbiter #(.IDLE_CYC(IDLE)) dut (
      .ref_clk_i(ref_clk_i),
      .rstn_i(rstn_i),
      .bus_clk_i(bus_clk_i),
      .status_n_i(status_n),
      .system_or_resident_select_i(sel),
      .io_bus_strap_i(io_s),
      .resident_bus_strap_i(res_s),
      .surrender_to_any_strap_i(any_s),
      .bus_keep_n_i(keep_n),
      .common_request_inhibit_i(inh),
      .priority_in_n_i(prio_n),
      .busy_i(busy_w),
      .common_bus_request_n_i(common_bus_request_n),
      .address_enable_n_o(aen_n),
      .bus_request_out_n_o(bus_request_out_n),
      .busy_o(busy_val),
      .busy_oe_o(busy_oe)
   );
   mba_far_model far (
      .ref_clk_i(ref_clk_i),
      .aen_n_i(aen_n),
      .bus_clk_i(bus_clk_i),
      .bus_request_out_n_i(bus_request_out_n),
      .busy_oe_i(busy_oe),
      .busy_val_i(busy_val),
      .rival_i(rival),
      .hog_i(hog),
      .low_req_i(low_req),
      .prio_n_o(prio_n),
      .busy_o(busy_w),
      .common_bus_request_n_o(common_bus_request_n),
      .cmd_o(cmd)
   );

   initial begin
      forever #2.5 ref_clk_i = ~ref_clk_i;
   end
   initial begin
      #17.3;
      forever #62.5 bus_clk_i = ~bus_clk_i;
   end

   task automatic tick(input int k);
      repeat (k) @(negedge ref_clk_i);
   endtask
   function automatic logic sig(input int k);
      return k == 0 ? aen_n : (k == 1 ? bus_request_out_n : busy_oe);
   endfunction
   task automatic wait_for(input int k, input logic lvl, output int w);
      w = 0;
      while (sig(k) !== lvl && w < 600) begin
         tick(1);
         w++;
      end
   endtask
   task automatic check(input string what, input logic seen, input logic exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s expected %b seen %b", what, exp, seen);
      end
   endtask
   task automatic do_reset();
      rstn_i = 1'h0;
      // Ten bus cycles: the bus side needs three of its own edges
      tick(250);
      rstn_i = 1'h1;
      tick(60);
      check("reset levels", aen_n & bus_request_out_n & ~busy_oe, 1'h1);
   endtask
   task automatic test_done();
      $display("Checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   initial begin
      foreach (rows[i]) begin
         io_s = rows[i].io;
         res_s = rows[i].res;
         sel = rows[i].sel;
         do_reset();
         status_n = rows[i].st;
         wait_for(1, 1'h0, n);
         check("bus_request_out_n", bus_request_out_n, ~rows[i].req);
         if (rows[i].req) begin
            wait_for(0, 1'h0, n);
            check("aen_n", aen_n, 1'h0);
            check("busy_oe", busy_oe, 1'h1);
            check("busy wire", busy_w, 1'h0);
            check("cmd disqualified", cmd, 1'h0);
            tick(5);
            check("cmd issued", cmd, 1'h1);
         end
         status_n = STATUS_PASSIVE;
         tick(20);
         $display("Row %0d done", i);
      end
      io_s = 1'h0;
      res_s = 1'h0;
      hog = 1'h1;
      do_reset();
      status_n = 3'h5;
      wait_for(1, 1'h0, n);
      tick(100);
      check("held off", busy_oe | ~aen_n, 1'h0);
      hog = 1'h0;
      wait_for(2, 1'h1, n);
      check("seize delay", n <= 55, 1'h1);
      wait_for(0, 1'h0, n);
      check("aen after seize", n <= 5, 1'h1);
      rival = 1'h1;
      tick(100);
      check("no early surrender", aen_n, 1'h0);
      status_n = STATUS_PASSIVE;
      wait_for(0, 1'h1, n);
      check("hold time", n >= CMD_HOLD_CYC && n <= 20, 1'h1);
      wait_for(1, 1'h1, n);
      check("bus_request_out released", n < 600, 1'h1);
      wait_for(2, 1'h0, n);
      check("busy after aen", aen_n & (n < 600), 1'h1);
      rival = 1'h0;
      $display("Seize and surrender done");
      status_n = 3'h5;
      wait_for(0, 1'h0, n);
      keep_n = 1'h0;
      rival = 1'h1;
      status_n = STATUS_PASSIVE;
      tick(300);
      check("kept", aen_n, 1'h0);
      keep_n = 1'h1;
      wait_for(0, 1'h1, n);
      check("keep release", n <= 20, 1'h1);
      rival = 1'h0;
      wait_for(1, 1'h1, n);
      check("bus_request_out after keep", bus_request_out_n, 1'h1);
      $display("Keep done");
      status_n = 3'h5;
      wait_for(0, 1'h0, n);
      status_n = STATUS_PASSIVE;
      tick(200);
      check("kept when unwanted", aen_n | bus_request_out_n, 1'h0);
      inh = 1'h1;
      low_req = 1'h1;
      tick(300);
      check("inhibit", aen_n, 1'h0);
      inh = 1'h0;
      wait_for(0, 1'h1, n);
      check("idle surrender", n <= 20, 1'h1);
      $display("Inhibit done");
      // Strap is only read as a level, reset keeps its change clean
      any_s = 1'h1;
      do_reset();
      status_n = 3'h5;
      wait_for(0, 1'h0, n);
      check("any grant", aen_n, 1'h0);
      status_n = STATUS_PASSIVE;
      wait_for(0, 1'h1, n);
      check("release to any", n < IDLE, 1'h1);
      $display("Any strap done");
      test_done();
   end

   initial begin
      #200000;
      bad_count++;
      test_done();
   end
endmodule
`default_nettype wire
